/* File: verilog/swpp_params.svh */
// Constants for the single-wire push-pull master
`ifndef SWPP_PARAMS_SVH
`define SWPP_PARAMS_SVH
`define SWPP_SUBTICKS      5'd16
`define SWPP_SUB_LAST      4'hf
`define SWPP_SAMPLE_SUB    4'h8
`define SWPP_START_SLOTS   3'd3
`define SWPP_PUSH_BITS     4'd9
`define SWPP_PULL_BITS     4'd8
`define SWPP_EOF_SLOTS     4'd8
`define SWPP_DATA_LSB      0
`define SWPP_DATA_MSB      4
`define SWPP_ADDR_LSB      5
`define SWPP_ADDR_MSB      7
`define SWPP_ALL_ONES      8'hff
`define SWPP_ALL_ZERO      8'h00
`endif

/* File: verilog/swpp_pkg.sv */
// Types for the single-wire push-pull master
package swpp_pkg;
  typedef enum logic [2:0] {
    SWPP_IDLE,
    SWPP_START,
    SWPP_PUSH,
    SWPP_PSYNC,
    SWPP_PULL,
    SWPP_EOF
  } swpp_state_e;
endpackage

/* File: verilog/swpp_rate_gen.sv */
// Baud divider producing a sub-tick enable pulse
`timescale 1ns/1ps
module swpp_rate_gen
  import swpp_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  // Divisor and tick
  input  wire logic [12:0] rate_divisor,
  output logic             sub_tick
);
  // ----------------------------------------
  // Divider
  // ----------------------------------------
  logic [12:0] count;          // Counts module clocks per sub-tick
  wire         run = (rate_divisor != 13'h0000); // Zero divisor stops the generator
  wire         wrap = run && (count >= rate_divisor - 13'h0001);

  // Counter restarts on wrap or when stopped
  always_ff @(posedge clk_sys) begin
    if (!nrst || !run || wrap) begin
      count <= 13'h0000;
    end else begin
      count <= count + 13'h0001;
    end
  end

  assign sub_tick = wrap; // RL18

  a_rate_stop: assert property (@(posedge clk_sys) disable iff (!nrst) // RL18
    (rate_divisor == 13'h0000) |-> !sub_tick) else $error("tick with zero divisor");
endmodule

/* File: verilog/swpp_master.sv */
// Single-wire push-pull link master with frame sequencer
// Link rules, master and slave side
// RL1: Start marker is three dominant-low slots
// RL2: Push sync bit is biphase zero
// RL3: Five biphase push data bits follow
// RL4: Three biphase address bits follow
// RL5: Write byte: low five data, top three address
// RL6: Master starts pull sync as biphase one
// RL7: Slave returns NRZ pull bits, one slot each
// RL8: Received pull byte lands in data register
// RL9: Slave sends square-wave end-of-frame when valid
// RL10: Each push bit spans two slots
// RL11: Zero is high-low, one is low-high
// RL12: Receiver ignores pin while pushing
// RL13: Master may start a frame any time
// RL14: Address selects one of eight slaves
// RL15: Uses serial transmit and receive pins
// RL16: Slave answers automatically after push field
// RL17: Valid needs non-extreme code and square-wave end
// RL18: Bit rate is clock over sixteen times divisor
// RL19: Slots are sixteen sub-ticks of rate generator
`timescale 1ns/1ps
`include "swpp_params.svh"
module swpp_master
  import swpp_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  // Software side
  input  wire logic [12:0] rate_divisor,
  input  wire logic        link_data_low_byte_wr,
  input  wire logic [7:0]  link_data_low_byte_in,
  output logic [7:0]       link_data_low_byte,
  output logic             frame_busy,
  output logic             frame_done,
  output logic             frame_valid,
  // Link pins
  output logic             serial_transmit_pin,
  input  wire logic        serial_receive_pin
);
  // ----------------------------------------
  // Slot timing
  // ----------------------------------------
  logic        sub_tick;       // One pulse per sixteenth of a slot
  logic [3:0]  sub_cnt;        // Position within the slot
  swpp_state_e state;          // Frame sequencer state
  logic [3:0]  bit_cnt;        // Bit or slot index inside a phase
  logic        half;           // Second slot of a biphase bit
  logic [8:0]  push_sr;        // Sync bit plus payload, LSB first
  logic [7:0]  pull_sr;        // Incoming pull bits
  logic        eof_prev;       // Last pull or end-of-frame sample
  logic        eof_ok;         // End-of-frame toggled every slot after its first
  logic [1:0]  slot_in_start;  // Start marker slot count

  swpp_rate_gen u_rate (
    .clk_sys      (clk_sys),
    .nrst         (nrst),
    .rate_divisor (rate_divisor),
    .sub_tick     (sub_tick)
  );

  wire slot_end  = sub_tick && (sub_cnt == `SWPP_SUB_LAST); // RL19
  wire sample_pt = sub_tick && (sub_cnt == `SWPP_SAMPLE_SUB);
  // Receiver sees the pin only during the pull and end-of-frame phases
  wire rx_live   = (state == SWPP_PULL) || (state == SWPP_EOF); // RL12
  wire rx_bit    = rx_live ? serial_receive_pin : 1'b1; // RL12 RL15
  // Biphase level: zero is high then low, one is low then high
  function automatic logic biphase(input logic b, input logic second);
    biphase = second ? b : ~b; // RL11
  endfunction

  // ----------------------------------------
  // Sub-slot counter
  // ----------------------------------------
  // Realigned at each new frame so slots start with the marker
  always_ff @(posedge clk_sys) begin
    if (!nrst || link_data_low_byte_wr) begin
      sub_cnt <= 4'h0;
    end else if (sub_tick) begin
      sub_cnt <= sub_cnt + 4'h1; // RL19
    end
  end

  // ----------------------------------------
  // Frame sequencer
  // ----------------------------------------
  // A write always wins, even mid-frame: the master owns the wire
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state <= SWPP_IDLE;
      bit_cnt <= 4'h0;
      half <= 1'b0;
      push_sr <= 9'h000;
      slot_in_start <= 2'd0;
    end else if (link_data_low_byte_wr) begin
      state <= SWPP_START; // RL13
      slot_in_start <= 2'd0;
      bit_cnt <= 4'h0;
      half <= 1'b0;
      push_sr <= {link_data_low_byte_in[`SWPP_ADDR_MSB:`SWPP_ADDR_LSB],
                  link_data_low_byte_in[`SWPP_DATA_MSB:`SWPP_DATA_LSB], 1'b0}; // RL2 RL5 RL14
    end else if (slot_end) begin
      case (state)
        SWPP_START: begin
          if ({1'b0, slot_in_start} == `SWPP_START_SLOTS - 3'd1) begin
            state <= SWPP_PUSH; // RL1
          end else begin
            slot_in_start <= slot_in_start + 2'd1;
          end
        end
        SWPP_PUSH: begin
          half <= ~half; // RL10
          if (half) begin
            push_sr <= {1'b0, push_sr[8:1]};
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == `SWPP_PUSH_BITS - 4'h1) begin
              state <= SWPP_PSYNC; // RL3 RL4
              bit_cnt <= 4'h0;
            end
          end
        end
        SWPP_PSYNC: begin
          half <= ~half;
          if (half) begin
            state <= SWPP_PULL; // RL6
          end
        end
        SWPP_PULL: begin
          bit_cnt <= bit_cnt + 4'h1;
          if (bit_cnt == `SWPP_PULL_BITS - 4'h1) begin
            state <= SWPP_EOF;
            bit_cnt <= 4'h0;
          end
        end
        SWPP_EOF: begin
          bit_cnt <= bit_cnt + 4'h1;
          if (bit_cnt == `SWPP_EOF_SLOTS - 4'h1) begin
            state <= SWPP_IDLE;
          end
        end
        default: state <= SWPP_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Pull data and end-of-frame check
  // ----------------------------------------
  // Pull bits are NRZ sampled mid-slot; end-of-frame must toggle each slot after its first
  always_ff @(posedge clk_sys) begin
    if (!nrst || link_data_low_byte_wr) begin
      pull_sr <= 8'h00;
      eof_prev <= 1'b1;
      eof_ok <= 1'b1;
    end else if (sample_pt && state == SWPP_PULL) begin
      pull_sr <= {rx_bit, pull_sr[7:1]}; // RL7
      eof_prev <= rx_bit;
    end else if (sample_pt && state == SWPP_EOF) begin
      eof_prev <= rx_bit;
      // First end-of-frame slot may match the last pull bit; only later slots must toggle
      if (rx_bit == eof_prev && bit_cnt != 4'h0) begin
        eof_ok <= 1'b0; // RL17
      end
    end
  end

  // ----------------------------------------
  // Results and pin
  // ----------------------------------------
  wire frame_end = slot_end && (state == SWPP_EOF) && (bit_cnt == `SWPP_EOF_SLOTS - 4'h1);
  wire code_ok   = (pull_sr != `SWPP_ALL_ONES) && (pull_sr != `SWPP_ALL_ZERO); // RL17

  // Data register is loaded at the end of the last end-of-frame slot
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      link_data_low_byte <= 8'h00;
      frame_done <= 1'b0;
      frame_valid <= 1'b0;
      serial_transmit_pin <= 1'b1;
    end else begin
      frame_done <= frame_end;
      if (frame_end) begin
        link_data_low_byte <= pull_sr; // RL8
        frame_valid <= code_ok && eof_ok; // RL17
      end
      case (state)
        SWPP_START: serial_transmit_pin <= 1'b0; // RL1
        SWPP_PUSH:  serial_transmit_pin <= biphase(push_sr[0], half); // RL11
        SWPP_PSYNC: serial_transmit_pin <= biphase(1'b1, half); // RL6
        default:    serial_transmit_pin <= 1'b1;
      endcase
    end
  end

  assign frame_busy = (state != SWPP_IDLE);

  a_start_low: assert property (@(posedge clk_sys) disable iff (!nrst) // RL1
    $past(state) == SWPP_START && state == SWPP_START |-> !serial_transmit_pin)
    else $error("start marker not low");
  a_push_order: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(state == SWPP_PSYNC) |-> $past(bit_cnt) == 4'h8) else $error("push bit count wrong"); // RL3
  a_rx_gated: assert property (@(posedge clk_sys) disable iff (!nrst)
    (state == SWPP_PUSH) |-> rx_bit) else $error("receiver not gated"); // RL12
  a_data_load: assert property (@(posedge clk_sys) disable iff (!nrst)
    frame_end |=> link_data_low_byte == $past(pull_sr)) else $error("pull byte not stored"); // RL8
  a_valid_codes: assert property (@(posedge clk_sys) disable iff (!nrst)
    frame_end && pull_sr == 8'hff |=> !frame_valid) else $error("all ones accepted"); // RL17
  a_write_starts: assert property (@(posedge clk_sys) disable iff (!nrst)
    link_data_low_byte_wr |=> state == SWPP_START) else $error("write did not start frame"); // RL13
  a_psync_first: assert property (@(posedge clk_sys) disable iff (!nrst) // RL6
    state == SWPP_PSYNC && !half ##1 state == SWPP_PSYNC && !half |-> !serial_transmit_pin)
    else $error("pull sync first slot not low");
endmodule

/* File: sim/swpp_slave_model.sv */
// Behavioural slave device on the shared wire
`timescale 1ns/1ps
module swpp_slave_model #(
  parameter int SLOT = 32,
  parameter int ADDR = 5
) (
  // Clock and wire
  input  wire logic       clk_sys,
  input  wire logic       wire_lvl,
  // Answer to give
  input  wire logic [7:0] reply,
  input  wire logic       square,
  output logic            pull_low
);
  int          lowcnt = 0;       // Low run seen on wire
  int          pos    = 1000000; // Clocks since frame start
  int          sl;               // Current slot number
  logic [17:0] push   = '0;      // Sampled push slots
  logic        drv;              // Level we let the wire take
  logic        sel;              // Our address was pushed
  // Own drive never counts as a start, else a zero reply restarts us
  always @(posedge clk_sys) begin
    lowcnt <= (wire_lvl || pull_low) ? 0 : lowcnt + 1;
    pos    <= (lowcnt == 5 * SLOT / 2) ? 5 * SLOT / 2 + 1 : pos + 1;
    if (pos % SLOT == SLOT / 2 && sl >= 3 && sl <= 20)
      push <= {wire_lvl, push[17:1]};
  end
  // Second slot of each biphase pair carries the bit
  assign sl  = pos / SLOT;
  assign sel = {push[17], push[15], push[13]} == ADDR;
  always_comb begin
    drv = 1'b1;
    if (sel && sl >= 23 && sl <= 30)
      drv = reply[sl-23];
    else if (sel && sl >= 31 && sl <= 38)
      drv = square ? sl[0] : 1'b1;
  end
  assign pull_low = ~drv;
endmodule

/* File: sim/swpp_master_bench.sv */
// Self-checking bench for the push-pull master
`timescale 1ns/1ps
module swpp_master_bench;
  localparam int S = 32; // Slot clocks at divisor 2
  logic        clk_sys = 0;
  logic        nrst    = 0;
  logic        wr      = 0;
  logic        sq      = 0;
  logic [12:0] div     = 13'h0002;
  logic [7:0]  din     = 8'h00;
  logic [7:0]  rep     = 8'h00;
  logic [7:0]  rd;
  logic        busy, done, valid, tx, pull_low;
  wire         lvl = tx & ~pull_low; // Pull-up wins when released
  int          miscompares = 0;
  int          n_compared  = 0;
  swpp_master uut (.clk_sys(clk_sys), .nrst(nrst), .rate_divisor(div),
    .link_data_low_byte_wr(wr), .link_data_low_byte_in(din), .link_data_low_byte(rd),
    .frame_busy(busy), .frame_done(done), .frame_valid(valid),
    .serial_transmit_pin(tx), .serial_receive_pin(lvl));
  swpp_slave_model #(.SLOT(S), .ADDR(5)) slave (.clk_sys(clk_sys), .wire_lvl(lvl),
    .reply(rep), .square(sq), .pull_low(pull_low));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("Compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic write(input logic [7:0] b);
    @(negedge clk_sys);
    din = b;
    wr  = 1'b1;
    @(negedge clk_sys);
    wr  = 1'b0;
  endtask
  // Whole frame: slot levels mid-slot through pull sync, length and pulled result
  task automatic t_frame(input logic [7:0] b, input logic [7:0] r, input logic s, input logic v);
    int   cyc, k, j;
    logic bv;
    rep = r;
    sq  = s;
    write(b);
    cyc = 0;
    while (done !== 1'b1 && cyc < 45 * S) begin
      @(negedge clk_sys);
      cyc++;
      k = (cyc - 1) / S;
      j = (k - 3) / 2;
      if ((cyc - 1) % S == S / 2 && k <= 22) begin
        bv = (k < 5) ? 1'b0 : (j == 9) ? 1'b1 : b[j-1];
        check("tx slot", tx, k < 3 ? 1'b0 : ((k - 3) % 2 ? bv : !bv));
      end
    end
    check("frame length", cyc >= 39 * S - 2 && cyc <= 39 * S + 4, 1'b1);
    check("pull byte", rd, b[7:5] == 3'h5 ? r : 8'hff);
    check("valid", valid, v);
  endtask
  // Zero divisor mid-frame holds the sequencer still
  task automatic t_freeze;
    logic hold;
    write(8'haa);
    repeat (5 * S) @(negedge clk_sys);
    div = 13'h0000;
    repeat (S) @(negedge clk_sys);
    hold = tx;
    repeat (4 * S) @(negedge clk_sys);
    check("frozen busy", busy, 1'b1);
    check("frozen tx", tx, hold);
    div = 13'h0002;
  endtask
  initial forever #5 clk_sys = ~clk_sys;
  // Hang guard, well past six frames
  initial begin
    #(80000 * 10);
    miscompares++;
    report_and_stop;
  end
  initial begin
    repeat (5) @(negedge clk_sys);
    nrst = 1'b1;
    check("reset tx", tx, 1'b1);
    check("reset data", rd, 8'h00);
    check("reset flags", {done, valid, busy}, 8'h00);
    t_frame(8'haa, 8'h3c, 1'b1, 1'b1);
    t_frame(8'hbf, 8'hff, 1'b0, 1'b0);
    t_frame(8'ha0, 8'h00, 1'b1, 1'b0);
    t_frame(8'h4a, 8'h3c, 1'b1, 1'b0);
    t_frame(8'hb3, 8'hbc, 1'b1, 1'b1);
    t_freeze;
    t_frame(8'hb5, 8'h5a, 1'b1, 1'b1);
    report_and_stop;
  end
endmodule
